// ===== core/sipe_consts.svh
// constants of the safe input pair evaluator: timing, offsets, fields, reset values
`ifndef SIPE_CONSTS_SVH
`define SIPE_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SIPE_CLK_HZ 50000000
`define SIPE_F_MIN_HZ 2
`define SIPE_F_MAX_HZ 500
`define SIPE_PULSE_US 350
`define SIPE_VEL_PER_HZ 10
`define SIPE_DIV_STEPS 5'h1f

// ----------------------------------------------------------------
// register map: group in paddr[7:5], word offset in paddr[4:0]
// ----------------------------------------------------------------
`define SIPE_GRP_CTRL 3'h0
`define SIPE_GRP_LIMIT 3'h1
`define SIPE_GRP_VEL 3'h2
`define SIPE_GRP_MAXVEL 3'h3
`define SIPE_OFF_MODE 5'h00
`define SIPE_OFF_TEST_EN 5'h04
`define SIPE_OFF_STATUS 5'h08
`define SIPE_OFF_INT_CLR 5'h0c
`define SIPE_OFF_INT_EN 5'h10
`define SIPE_OFF_DIAG 5'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SIPE_ST_OVF_LSB 0
`define SIPE_ST_MAT_LSB 8
`define SIPE_ACK_BIT 0
`define SIPE_MODE_RST 16'h0000
`define SIPE_TEST_EN_RST 8'hff
`define SIPE_LIMIT_RST 16'h1388
`define SIPE_INT_EN_RST 12'h000

`endif

// ===== core/sipe_evaluator.sv
// safe input pair evaluator: pair modes, speed monitor, apb registers
//
// Function
// - single mode: each channel reported on its own
// - pulsed modes tolerate low pulses to 350 us
// - any-repetition mode accepts coincident pulses
// - mat cross-circuit forces both channels to zero
// - speed channel high only below its limit
// - mixed mode: individual channel passes its input
// - below 2 Hz measured frequency reads zero
// - above 500 Hz raises a diagnostic
// - diagnostic latched until acknowledge rising edge
// - dual speed: each channel its own limit
// - frequency held per channel in 0.1 Hz
// - acknowledge is bit zero of safe output data
// - per-channel maximum frequency since communication start
`timescale 1ns/1ps
`include "sipe_consts.svh"
module sipe_evaluator #(
  parameter int unsigned CLK_HZ = `SIPE_CLK_HZ,
  parameter int unsigned PULSE_CYC = `SIPE_PULSE_US * (`SIPE_CLK_HZ / 1000000),
  parameter int unsigned MIN_PERIOD_CYC = `SIPE_CLK_HZ / `SIPE_F_MAX_HZ,
  parameter int unsigned MAX_PERIOD_CYC = `SIPE_CLK_HZ / `SIPE_F_MIN_HZ,
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sipe_pkg::sipe_field_t field,
  input wire logic [7:0] safe_out_data,
  input wire logic comm_start,
  output logic [7:0] safe_in_data,
  output logic [7:0] over_freq_diag,
  output logic irq
);
  import sipe_pkg::*;

  localparam int PW = $clog2(MAX_PERIOD_CYC + 2);
  localparam int FW = $clog2(PULSE_CYC + 1);
  localparam logic [PW-1:0] P_MAX = PW'(MAX_PERIOD_CYC);
  localparam logic [PW-1:0] P_MIN = PW'(MIN_PERIOD_CYC);
  localparam logic [FW-1:0] PULSE_LIM = FW'(PULSE_CYC);
  localparam logic [31:0] NUM = 32'(CLK_HZ * `SIPE_VEL_PER_HZ);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic sipe_mode_t pair_mode(input logic [15:0] r, input int p);
    pair_mode = sipe_mode_t'(r[4*p +: 3]);
  endfunction

  // true when channel c of its pair runs the speed monitor
  function automatic logic is_vel(input sipe_mode_t m, input logic odd);
    is_vel = (m == MODE_VEL_XY) || (m == MODE_VEL_X && !odd) || (m == MODE_VEL_Y && odd);
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 3'(k);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [7:0] test_en;
  logic [11:0] int_en;
  logic [11:0] status;
  logic [15:0] limit [8];
  logic [15:0] vel [8];
  logic [7:0] diag;
  logic [7:0] lvl_prev;
  logic [7:0] armed;
  logic [PW-1:0] period_cnt [8];
  logic [PW-1:0] period_cap [8];
  logic [7:0] meas_req;
  logic [FW-1:0] low_cnt [8];
  logic [3:0] mat_short;
  logic ack_prev;
  logic [7:0] max_valid;
  sipe_div_state_t div_state;
  logic [2:0] div_ch;
  logic [4:0] div_step;
  logic [31:0] quo;
  logic [32:0] rem;
  logic [PW-1:0] dvs;

  logic [7:0] rise;
  logic [7:0] set_req;
  logic [7:0] ovf_evt;
  logic [7:0] vel_chan;
  logic [3:0] mat_evt;
  logic ack_rise;
  logic [2:0] pick;
  logic take;
  logic [7:0] take_mask;
  logic [15:0] q16;
  logic [15:0] max_rd_a;
  logic [15:0] max_rd_b;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic acc;
  logic wr;
  logic [11:0] int_clr;
  logic [7:0] next_safe_in;
  logic [31:0] next_rdata;
  logic next_err;

  // ----------------------------------------------------------------
  // combinational event terms
  // ----------------------------------------------------------------
  assign rise = field.level & ~lvl_prev;
  assign ack_rise = safe_out_data[`SIPE_ACK_BIT] & ~ack_prev;
  assign pick = first_set(meas_req);
  assign take = (div_state == DIV_IDLE) && (|meas_req);
  assign take_mask = take ? (8'h01 << pick) : 8'h00;
  assign q16 = (|quo[31:16]) ? 16'hffff : quo[15:0];

  // per-channel mode decode, measurement requests and over-frequency
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      vel_chan[i] = is_vel(pair_mode(mode_reg, i / 2), i[0]);
      set_req[i] = armed[i] && (rise[i] || period_cnt[i] == P_MAX);
      // period shorter than the 500 Hz period
      ovf_evt[i] = vel_chan[i] && armed[i] && rise[i] && (period_cnt[i] + 1'b1 < P_MIN);
    end
  end

  // ----------------------------------------------------------------
  // period measurement per channel
  // ----------------------------------------------------------------
  // a channel that sits still for the 2 Hz period is disarmed and reads 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev <= 8'h00;
      armed <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        period_cnt[i] <= '0;
        period_cap[i] <= '0;
      end
    end else begin
      lvl_prev <= field.level;
      for (int i = 0; i < 8; i++) begin
        if (rise[i]) begin
          period_cnt[i] <= '0;
          armed[i] <= 1'b1;
          period_cap[i] <= period_cnt[i] + 1'b1;
        end else if (period_cnt[i] == P_MAX) begin
          armed[i] <= 1'b0;
          period_cap[i] <= '0;
        end else begin
          period_cnt[i] <= period_cnt[i] + 1'b1;
        end
      end
    end
  end

  // pending divides; a new capture wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_req <= 8'h00;
    end else begin
      meas_req <= (meas_req & ~take_mask) | set_req;
    end
  end

  // ----------------------------------------------------------------
  // shared serial divider: velocity = clk * 10 / period, 0.1 Hz units
  // ----------------------------------------------------------------
  // one divider for all channels: 34 cycles per result, far below 2 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state <= DIV_IDLE;
      div_ch <= 3'h0;
      div_step <= 5'h00;
      quo <= 32'h0;
      rem <= 33'h0;
      dvs <= '0;
      for (int i = 0; i < 8; i++) begin
        vel[i] <= 16'h0000;
      end
    end else begin
      case (div_state)
        DIV_IDLE: begin
          if (take) begin
            div_ch <= pick;
            if (period_cap[pick] == '0) begin
              vel[pick] <= 16'h0000;
            end else begin
              quo <= NUM;
              rem <= 33'h0;
              dvs <= period_cap[pick];
              div_step <= 5'h00;
              div_state <= DIV_RUN;
            end
          end
        end
        DIV_RUN: begin
          if ({rem[31:0], quo[31]} >= 33'(dvs)) begin
            rem <= {rem[31:0], quo[31]} - 33'(dvs);
            quo <= {quo[30:0], 1'b1};
          end else begin
            rem <= {rem[31:0], quo[31]};
            quo <= {quo[30:0], 1'b0};
          end
          div_step <= div_step + 5'h01;
          if (div_step == `SIPE_DIV_STEPS) begin
            div_state <= DIV_DONE;
          end
        end
        DIV_DONE: begin
          vel[div_ch] <= q16;
          div_state <= DIV_IDLE;
        end
        default: begin
          div_state <= DIV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // maximum frequency since communication start
  // ----------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = div_ch;
    mem_wdata = q16;
    if (div_state == DIV_DONE) begin
      mem_we = !max_valid[div_ch] || (q16 > max_rd_b);
    end else if (take && period_cap[pick] == '0 && !max_valid[pick]) begin
      mem_we = 1'b1;
      mem_waddr = pick;
      mem_wdata = 16'h0000;
    end
  end

  // restart of communication forgets every stored maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_valid <= 8'h00;
    end else if (comm_start) begin
      max_valid <= 8'h00;
    end else if (mem_we) begin
      max_valid[mem_waddr] <= 1'b1;
    end
  end

  sipe_vel_mem #(.W(16), .D(8), .AW(3)) u_max_mem (
    .clk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(paddr[4:2]),
    .rdata_a(max_rd_a),
    .raddr_b(div_ch),
    .rdata_b(max_rd_b)
  );

  // ----------------------------------------------------------------
  // diagnostic latch and acknowledge edge
  // ----------------------------------------------------------------
  // a new over-frequency in the acknowledge cycle stays latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_prev <= 1'b0;
      diag <= 8'h00;
    end else begin
      ack_prev <= safe_out_data[`SIPE_ACK_BIT];
      diag <= (diag & ~{8{ack_rise}}) | ovf_evt;
    end
  end

  // ----------------------------------------------------------------
  // pulse filter and safety mat cross-circuit
  // ----------------------------------------------------------------
  // counts consecutive low cycles, saturating at the tolerated width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        low_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (field.level[i]) begin
          low_cnt[i] <= '0;
        end else if (low_cnt[i] != PULSE_LIM) begin
          low_cnt[i] <= low_cnt[i] + 1'b1;
        end
      end
    end
  end

  // input follows the partner's pulse while its own output is high
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      mat_evt[p] = (pair_mode(mode_reg, p) == MODE_MAT) && (&test_en[2*p +: 2]) &&
        ((!field.pulse[2*p] && field.pulse[2*p+1] && !field.level[2*p+1]) ||
         (!field.pulse[2*p+1] && field.pulse[2*p] && !field.level[2*p]));
    end
  end

  // short latched until both inputs are high with no pulse running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mat_short <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (mat_evt[p]) begin
          mat_short[p] <= 1'b1;
        end else if ((&field.level[2*p +: 2]) && (&field.pulse[2*p +: 2])) begin
          mat_short[p] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // safe input data per channel
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (pair_mode(mode_reg, i / 2))
        MODE_SINGLE: next_safe_in[i] = field.level[i];
        MODE_OSSD_ASYNC: begin
          // coincident lows are not pulses here, so they drop at once
          next_safe_in[i] = field.level[i] || (field.level[i ^ 1] &&
            low_cnt[i] < PULSE_LIM);
        end
        MODE_OSSD_ANY: next_safe_in[i] = field.level[i] || low_cnt[i] < PULSE_LIM;
        MODE_MAT: begin
          next_safe_in[i] = (field.level[i] || !field.pulse[i]) && !mat_short[i / 2];
        end
        MODE_VEL_X, MODE_VEL_Y, MODE_VEL_XY: begin
          if (vel_chan[i]) begin
            next_safe_in[i] = (vel[i] < limit[i]) && !diag[i];
          end else begin
            next_safe_in[i] = field.level[i];
          end
        end
        default: next_safe_in[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_in_data <= 8'h00;
      over_freq_diag <= 8'h00;
    end else begin
      safe_in_data <= next_safe_in;
      over_freq_diag <= diag;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 12'h000;
      irq <= 1'b0;
    end else begin
      status <= (status & ~int_clr) | {mat_evt, ovf_evt};
      irq <= |(status & int_en);
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state on every access
  // ----------------------------------------------------------------
  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign int_clr = (wr && paddr[7:5] == `SIPE_GRP_CTRL && paddr[4:0] == `SIPE_OFF_INT_CLR) ?
    pwdata[11:0] : 12'h000;

  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (paddr[7:5])
      `SIPE_GRP_CTRL: begin
        case (paddr[4:0])
          `SIPE_OFF_MODE: next_rdata = {16'h0, mode_reg};
          `SIPE_OFF_TEST_EN: next_rdata = {24'h0, test_en};
          `SIPE_OFF_STATUS: next_rdata = {20'h0, status};
          `SIPE_OFF_INT_CLR: next_rdata = 32'h0;
          `SIPE_OFF_INT_EN: next_rdata = {20'h0, int_en};
          `SIPE_OFF_DIAG: next_rdata = {16'h0, safe_in_data, diag};
          default: next_err = 1'b1;
        endcase
      end
      `SIPE_GRP_LIMIT: next_rdata = {16'h0, limit[paddr[4:2]]};
      `SIPE_GRP_VEL: next_rdata = {16'h0, vel[paddr[4:2]]};
      `SIPE_GRP_MAXVEL: next_rdata = max_valid[paddr[4:2]] ? {16'h0, max_rd_a} : 32'h0;
      default: next_err = 1'b1;
    endcase
    if (paddr[1:0] != 2'b00) begin
      next_err = 1'b1;
    end
    if (pwrite && paddr[7:6] != 2'b00) begin
      next_err = 1'b1;
    end
    if (next_err) begin
      next_rdata = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc && next_err;
      if (acc) begin
        prdata <= next_rdata;
      end
    end
  end

  // writable registers, taken at the edge that samples pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `SIPE_MODE_RST;
      test_en <= `SIPE_TEST_EN_RST;
      int_en <= `SIPE_INT_EN_RST;
      for (int i = 0; i < 8; i++) begin
        limit[i] <= `SIPE_LIMIT_RST;
      end
    end else if (wr) begin
      if (paddr[7:5] == `SIPE_GRP_LIMIT) begin
        limit[paddr[4:2]] <= pwdata[15:0];
      end else begin
        case (paddr[4:0])
          `SIPE_OFF_MODE: mode_reg <= pwdata[15:0];
          `SIPE_OFF_TEST_EN: test_en <= pwdata[7:0];
          `SIPE_OFF_INT_EN: int_en <= pwdata[11:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_edge_s;
    !safe_out_data[0] ##1 safe_out_data[0];
  endsequence

  ack_clears_a: assert property (ack_edge_s ##0 (ovf_evt == 8'h00) |=> diag == 8'h00)
    else $error("diagnostic not cleared by acknowledge edge");
  diag_holds_a: assert property (!ack_rise |=> (diag & $past(diag)) == $past(diag))
    else $error("diagnostic dropped without acknowledge");
  ovf_latch_a: assert property (|ovf_evt |=> ##1 (over_freq_diag & $past(ovf_evt, 2)) != 8'h00)
    else $error("over-frequency not shown on diagnostic output");
  single_pass_a: assert property (pair_mode(mode_reg, 0) == MODE_SINGLE |=>
    safe_in_data[1:0] == $past(field.level[1:0]))
    else $error("single mode does not follow inputs");
  mixed_pass_a: assert property (pair_mode(mode_reg, 0) == MODE_VEL_X |=>
    safe_in_data[1] == $past(field.level[1]) &&
    safe_in_data[0] == ($past(vel[0] < limit[0]) && !$past(diag[0])))
    else $error("mixed mode output wrong");
  dual_limit_a: assert property (pair_mode(mode_reg, 1) == MODE_VEL_XY |=>
    safe_in_data[3] == ($past(vel[3] < limit[3]) && !$past(diag[3])))
    else $error("dual speed channel ignores own limit");
  diag_forces_a: assert property (diag[2] && vel_chan[2] |=> !safe_in_data[2])
    else $error("latched diagnostic did not force zero");
  pulse_tol_a: assert property (pair_mode(mode_reg, 0) == MODE_OSSD_ANY &&
    low_cnt[0] < PULSE_LIM && low_cnt[1] < PULSE_LIM |=> safe_in_data[1:0] == 2'b11)
    else $error("short pulse not tolerated");
  async_both_a: assert property (pair_mode(mode_reg, 0) == MODE_OSSD_ASYNC &&
    field.level[1:0] == 2'b00 |=> safe_in_data[1:0] == 2'b00)
    else $error("coincident lows passed in async mode");
  mat_zero_a: assert property (pair_mode(mode_reg, 0) == MODE_MAT && mat_short[0] |=>
    safe_in_data[1:0] == 2'b00)
    else $error("cross-circuit did not force pair to zero");
  under_zero_a: assert property (take && period_cap[pick] == '0 |=> vel[$past(pick)] == 16'h0)
    else $error("low frequency not reported as zero");
  apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
endmodule

// ===== core/sipe_pkg.sv
// types shared by the safe input pair evaluator
package sipe_pkg;

  // operating mode of one input pair
  typedef enum logic [2:0] {
    MODE_SINGLE,
    MODE_OSSD_ASYNC,
    MODE_OSSD_ANY,
    MODE_MAT,
    MODE_VEL_X,
    MODE_VEL_Y,
    MODE_VEL_XY
  } sipe_mode_t;

  // divider sequencing
  typedef enum logic [1:0] {
    DIV_IDLE,
    DIV_RUN,
    DIV_DONE
  } sipe_div_state_t;

  // field side: input levels and state of the test pulse outputs (1 = no pulse)
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] pulse;
  } sipe_field_t;

endpackage

// ===== core/sipe_vel_mem.sv
// small word memory with one write port and two registered read ports
`timescale 1ns/1ps
module sipe_vel_mem #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  logic [W-1:0] mem [D];

  // write port; no reset, validity is tracked by the user
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered reads, one cycle after the address
  always_ff @(posedge clk) begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

// ===== verif/sipe_sensor_model.sv
// field-side model: switches with static levels or a square wave per channel
`timescale 1ns/1ps
module sipe_sensor_model (
  input wire logic pclk,
  input wire logic [7:0] stat_level,
  input wire logic [7:0] run,
  input wire logic [15:0] half,
  input wire logic [7:0] pls,
  output sipe_pkg::sipe_field_t field
);
  import sipe_pkg::*;
  logic [15:0] cnt = 16'h0000;
  logic sq = 1'b0;
  // one square wave for all running channels, period of two half periods
  always @(posedge pclk) begin
    if (cnt + 16'h0001 >= half) begin
      cnt <= 16'h0000;
      sq <= ~sq;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  // pulse outputs as the bench asks for them (1 = no pulse running)
  always_comb begin
    field.level = (run & {8{sq}}) | (~run & stat_level);
    field.pulse = pls;
  end
endmodule

// ===== verif/testbench.sv
// self-checking bench of the safe input pair evaluator
`timescale 1ns/1ps
module testbench;
  import sipe_pkg::*;
  localparam int unsigned CLKF = 4000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, safe_out_data = 8'h00, stat_level = 8'hff, run = 8'h00, pls = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, vexp;
  logic pready, pslverr, comm_start = 1'b0, irq;
  logic [15:0] half = 16'h0032;
  logic [7:0] safe_in_data, over_freq_diag;
  logic [33:0] e;
  logic [33:0] expq[$];
  sipe_field_t field;
  int seed = 5, miscompares = 0, compares = 0;
  // ----------------------------------------------------------------
  // clock, design and field model
  // ----------------------------------------------------------------
  initial forever #10 pclk = ~pclk;
  sipe_evaluator #(.CLK_HZ(CLKF), .PULSE_CYC(20), .MIN_PERIOD_CYC(40), .MAX_PERIOD_CYC(400))
    u_sipe_evaluator (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .field(field), .safe_out_data(safe_out_data),
    .comm_start(comm_start), .safe_in_data(safe_in_data),
    .over_freq_diag(over_freq_diag), .irq(irq));
  sipe_sensor_model u_sipe_sensor_model (.pclk(pclk), .stat_level(stat_level), .run(run),
    .half(half), .pls(pls), .field(field));
  // ----------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("counts: compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // stop a running channel only while it is high, so the stop makes no rising edge
  task wait_high(input logic [7:0] m);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((field.level & m) != m && k < 200);
    if (k >= 200) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  // one apb transfer; the expected answer goes to the queue first
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    expq.push_back({~wr, err, d});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      report_and_stop;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk(prdata, e[31:0]);
    end
  end
  // low pulse on masked inputs; output looked at just after the pulse ends, as set in its last low cycle
  task pulse(input logic [7:0] m, input int n, input logic [7:0] expv);
    @(posedge pclk);
    stat_level <= ~m;
    repeat (n) @(posedge pclk);
    stat_level <= 8'hff;
    #1;
    chk(safe_in_data & m, expv);
    repeat (3) @(posedge pclk);
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 32'h0, 0);
    apb(0, 8'h04, 32'hff, 0);
    apb(0, 8'h20, 32'h1388, 0);
    apb(0, 8'h10, 32'h0, 0);
    apb(0, 8'h18, 32'h0, 1);
    apb(1, 8'h40, 32'h5, 1);
    for (i = 0; i < 7; i++) begin
      apb(1, 8'h00, 32'(i), 0);
      apb(0, 8'h00, 32'(i), 0);
    end
    apb(1, 8'h00, 32'h0, 0);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      stat_level <= 8'($random(seed));
      tick(3);
      chk(safe_in_data, stat_level);
    end
    $display("test registers and single mode done");
    // async and any-repetition pulsed modes, single and coincident pulses; sensor test off on pair 0
    @(posedge pclk);
    stat_level <= 8'hff;
    apb(1, 8'h04, 32'hfc, 0);
    apb(1, 8'h00, 32'h1, 0);
    pulse(8'h01, 20, 8'h01);
    pulse(8'h02, 20, 8'h02);
    pulse(8'h01, 30, 8'h00);
    pulse(8'h03, 5, 8'h00);
    apb(1, 8'h00, 32'h2, 0);
    pulse(8'h03, 20, 8'h03);
    $display("test pulsed modes done");
    // dual speed on pair 1, separate limits 30.0 Hz and 50.0 Hz
    apb(1, 8'h00, 32'h60, 0);
    apb(1, 8'h28, 32'h12c, 0);
    apb(1, 8'h2c, 32'h1f4, 0);
    comm_start <= 1'b1;
    @(posedge pclk);
    comm_start <= 1'b0;
    run <= 8'h0c;
    vexp = 32'(CLKF * 10 / (2 * half));
    tick(600);
    chk(safe_in_data & 8'h0c, 8'h08);
    apb(0, 8'h48, vexp, 0);
    apb(0, 8'h6c, vexp, 0);
    wait_high(8'h0c);
    run <= 8'h00;
    tick(600);
    apb(0, 8'h48, 32'h0, 0);
    chk(safe_in_data & 8'h0c, 8'h0c);
    comm_start <= 1'b1;
    @(posedge pclk);
    comm_start <= 1'b0;
    apb(0, 8'h6c, 32'h0, 0);
    $display("test speed done");
    // over-frequency on channel 2 while its interrupt is masked
    half <= 16'h000a;
    run <= 8'h04;
    tick(100);
    wait_high(8'h04);
    run <= 8'h00;
    tick(5);
    chk(over_freq_diag, 8'h04);
    chk(safe_in_data & 8'h04, 8'h00);
    chk(irq, 1'b0);
    apb(1, 8'h10, 32'h4, 0);
    tick(3);
    chk(irq, 1'b1);
    apb(1, 8'h0c, 32'h4, 0);
    tick(3);
    chk(irq, 1'b0);
    apb(0, 8'h08, 32'h0, 0);
    safe_out_data <= 8'h02;
    tick(4);
    chk(over_freq_diag, 8'h04);
    @(posedge pclk);
    safe_out_data <= 8'h03;
    tick(4);
    chk(over_freq_diag, 8'h00);
    $display("test diagnostic and interrupt done");
    // safety mat on pair 0: own pulse alone reads 1, a cross-circuit zeros the pair
    apb(1, 8'h04, 32'hff, 0);
    apb(1, 8'h00, 32'h3, 0);
    @(posedge pclk);
    pls <= 8'hfe;
    stat_level <= 8'hfe;
    tick(2);
    chk(safe_in_data & 8'h03, 8'h03);
    @(posedge pclk);
    stat_level <= 8'hfc;
    tick(3);
    chk(safe_in_data & 8'h03, 8'h00);
    @(posedge pclk);
    pls <= 8'hff;
    stat_level <= 8'hff;
    tick(3);
    chk(safe_in_data & 8'h03, 8'h03);
    apb(0, 8'h08, 32'h100, 0);
    // mixed mode on pair 0: speed channel still at zero, partner follows its input
    apb(1, 8'h00, 32'h4, 0);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      stat_level <= 8'($random(seed)) | 8'hfd;
      tick(3);
      chk(safe_in_data & 8'h03, 8'h01 | (stat_level & 8'h02));
    end
    $display("test mat and mixed modes done");
    report_and_stop;
  end
endmodule
